/* shared/can_debug_defs.svh */
`ifndef CAN_DEBUG_DEFS_SVH
`define CAN_DEBUG_DEFS_SVH

// Register byte offsets
`define REG_MODULE_CTRL 8'h00
`define REG_STD_FILTER 8'h04
`define REG_EXT_FILTER 8'h08
`define REG_RXBUF_CFG 8'h0c
`define REG_TXBUF_CFG 8'h10
`define REG_BUF_ADDR 8'h14
`define REG_TXBUF_WORD0 8'h18
`define REG_STATUS 8'h1c

// Module control fields
`define MCR_ENABLE_BIT 27
`define MCR_NODE_HI 26
`define MCR_NODE_LO 24

// Standard filter element fields
`define SFE_ACTION_HI 29
`define SFE_ACTION_LO 27
`define SFE_ID1_HI 26
`define SFE_ID1_LO 16
`define SFE_ID2_HI 10
`define SFE_ID2_LO 0
`define SFE_ACTION_DEBUG 3'h7
`define SFE_ID2_DEBUG 11'h000

// Extended filter register: valid flag and 29-bit identifier
`define EXT_FILTER_VALID_BIT 31
`define EXT_FILTER_ID_HI 28
`define EXT_FILTER_ID_LO 0

// Transmit buffer word 0 fields
`define TXW0_EXT_BIT 30
`define TXW0_ID_HI 28
`define TXW0_ID_LO 0
`define STD_ID_SHIFT 18
`define STD_ID_HI 28
`define STD_ID_LO 18

// Debug buffer address register: word addresses
`define BUFADDR_RX_HI 15
`define BUFADDR_RX_LO 0
`define BUFADDR_TX_HI 31
`define BUFADDR_TX_LO 16
`define BUFCFG_ADDR_HI 17
`define BUFCFG_ADDR_LO 2

// Request and reply lengths in bytes
`define DLC_READ_REQ 4'h4
`define DLC_WRITE_REQ 4'h8
`define DLC_READ_REPLY 4'h4
`define DLC_WRITE_REPLY 4'h0

// Status fields
`define STAT_ACTIVE_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_ADDR_OK_BIT 2
`define STAT_REFUSED_BIT 3
`define STAT_DROP_HI 15
`define STAT_DROP_LO 8
`define STAT_REPLY_HI 23
`define STAT_REPLY_LO 16

`define DEBUG_RXBUF_INDEX 1'b0
`define DEBUG_TXBUF_INDEX 1'b0

`endif

/* shared/can_debug_pkg.sv */
package can_debug_pkg;
  typedef logic [28:0] can_id_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [2:0] node_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_REPLY = 3'b100
  } chan_state_t;
endpackage : can_debug_pkg

/* rtl/debug_filter_match.sv */
`timescale 1ns/1ns
`include "can_debug_defs.svh"
module debug_filter_match
  import can_debug_pkg::*;
(
  input wire logic [31:0] std_filter,
  input wire logic [31:0] ext_filter,
  input wire can_debug_pkg::can_id_t frame_id,
  input wire logic frame_ext,
  output logic hit
);
  logic std_hit;
  logic ext_hit;

  always_comb begin
    // [RULE_05] Action seven only
    // The filter type select field is not looked at.
    std_hit = (std_filter[`SFE_ACTION_HI:`SFE_ACTION_LO]
               == `SFE_ACTION_DEBUG);
    // [RULE_07] Secondary field zero
    std_hit = std_hit && (std_filter[`SFE_ID2_HI:`SFE_ID2_LO]
                          == `SFE_ID2_DEBUG);
    // [RULE_06] Identifier compare
    std_hit = std_hit && !frame_ext &&
              (frame_id[`SFE_ID1_HI - `SFE_ID1_LO:0]
               == std_filter[`SFE_ID1_HI:`SFE_ID1_LO]);
    // [RULE_03] Extended request identifier
    ext_hit = ext_filter[`EXT_FILTER_VALID_BIT] && frame_ext &&
              (frame_id ==
               ext_filter[`EXT_FILTER_ID_HI:`EXT_FILTER_ID_LO]);
    hit = std_hit || ext_hit;
  end
endmodule : debug_filter_match

/* rtl/can_message_debug_channel.sv */
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "can_debug_defs.svh"
// Function
// [RULE_01] Each accepted request produces exactly one short reply frame.
// [RULE_02] Reply copies request format: classic or FD, with or without BRS.
// [RULE_03] Request and reply identifiers are separate, standard or extended.
// [RULE_04] Receive buffer 0 holds only debug requests.
// [RULE_05] Filter action 7 in bits 29:27 routes to debug; type ignored.
// [RULE_06] Filter bits 26:16 hold the request identifier to match.
// [RULE_07] Filter bits 10:0 must be zero for the debug rule.
// [RULE_08] Transmit buffer 0 word 0 bit 30 selects extended identifier.
// [RULE_09] Reply identifier in bits 28:0, standard ids shifted up 18.
// [RULE_10] Channel fills all other reply settings itself or from request.
// [RULE_11] Buffer address register omits two low bits of config addresses.
// [RULE_12] Control bits 26:24 select the CAN node for debug traffic.
// [RULE_13] Control bit 27 enables the channel; clear keeps it inactive.
// [RULE_14] Once enabled, a later port debugger attach is refused.
// [RULE_15] Enabling with port debugger attached leaves channel disabled.
// [RULE_16] No halt at reset vector through this channel.
// [RULE_17] Channel only on nodes of the first multi-node CAN module.
// [RULE_18] Host should give the reply identifier high bus priority.
// [RULE_19] Non-matching frames take the normal path, untouched by debug.
module can_message_debug_channel
  import can_debug_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire can_debug_pkg::reg_addr_t reg_addr,
  input wire can_debug_pkg::word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output can_debug_pkg::word_t reg_rdata,
  input wire logic rx_valid,
  input wire can_debug_pkg::can_id_t rx_id,
  input wire logic rx_ext,
  input wire logic rx_fdf,
  input wire logic rx_brs,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire can_debug_pkg::node_t rx_node,
  input wire logic rx_first_module,
  output logic norm_valid,
  output can_debug_pkg::can_id_t norm_id,
  output logic norm_ext,
  output logic [3:0] norm_dlc,
  output logic [63:0] norm_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output can_debug_pkg::can_id_t tx_id,
  output logic tx_ext,
  output logic tx_fdf,
  output logic tx_brs,
  output logic [3:0] tx_dlc,
  output can_debug_pkg::word_t tx_data,
  output logic dbg_req,
  output can_debug_pkg::word_t dbg_addr,
  output can_debug_pkg::word_t dbg_wdata,
  output logic dbg_we,
  input wire logic dbg_ack,
  input wire can_debug_pkg::word_t dbg_rdata,
  input wire logic dap_attached,
  output logic dap_attach_block
);

  word_t mcr_r;
  word_t std_filter_r;
  word_t ext_filter_r;
  word_t rxbuf_cfg_r;
  word_t txbuf_cfg_r;
  word_t buf_addr_r;
  word_t txw0_r;
  logic enable_r;
  logic refused_r;
  logic [7:0] drop_cnt_r;
  logic [7:0] reply_cnt_r;
  chan_state_t state_r;
  chan_state_t state_nxt;
  // Receive buffer 0: two payload words of the pending request
  word_t rxbuf_r [2];
  logic req_write_r;
  logic req_fdf_r;
  logic req_brs_r;
  logic filter_hit;
  logic node_ok;
  logic addr_ok;
  logic debug_frame;
  logic accept;

  function automatic logic reg_hit(input reg_addr_t a, input reg_addr_t o);
    reg_hit = (a == o);
  endfunction : reg_hit

  function automatic can_id_t reply_id(input word_t w0);
    // [RULE_09] Left-aligned standard id
    if (w0[`TXW0_EXT_BIT]) begin
      reply_id = w0[`TXW0_ID_HI:`TXW0_ID_LO];
    end else begin
      reply_id = can_id_t'(w0[`STD_ID_HI:`STD_ID_LO]);
    end
  endfunction : reply_id

  debug_filter_match u_filter (
    .std_filter(std_filter_r),
    .ext_filter(ext_filter_r),
    .frame_id(rx_id),
    .frame_ext(rx_ext),
    .hit(filter_hit)
  );

  // [RULE_11] Word addresses versus byte addresses
  assign addr_ok = (buf_addr_r[`BUFADDR_RX_HI:`BUFADDR_RX_LO] ==
                    rxbuf_cfg_r[`BUFCFG_ADDR_HI:`BUFCFG_ADDR_LO]) &&
                   (buf_addr_r[`BUFADDR_TX_HI:`BUFADDR_TX_LO] ==
                    txbuf_cfg_r[`BUFCFG_ADDR_HI:`BUFCFG_ADDR_LO]);

  // [RULE_12] Node select
  // [RULE_17] First module only
  assign node_ok = rx_first_module &&
                   (rx_node == mcr_r[`MCR_NODE_HI:`MCR_NODE_LO]);

  // [RULE_13] Inactive unless enabled
  assign debug_frame = enable_r && addr_ok && node_ok && filter_hit;
  // A request that lands while one is in flight is dropped, so the
  // one-to-one pairing holds only for requests that were taken.
  assign accept = rx_valid && debug_frame && (state_r == ST_IDLE);

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_r <= 32'h0000_0000;
      std_filter_r <= 32'h0000_0000;
      ext_filter_r <= 32'h0000_0000;
      rxbuf_cfg_r <= 32'h0000_0000;
      txbuf_cfg_r <= 32'h0000_0000;
      buf_addr_r <= 32'h0000_0000;
      txw0_r <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, `REG_MODULE_CTRL)) begin
        mcr_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_STD_FILTER)) begin
        std_filter_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_EXT_FILTER)) begin
        ext_filter_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_RXBUF_CFG)) begin
        rxbuf_cfg_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_TXBUF_CFG)) begin
        txbuf_cfg_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_BUF_ADDR)) begin
        buf_addr_r <= reg_wdata;
      end
      if (reg_hit(reg_addr, `REG_TXBUF_WORD0)) begin
        // [RULE_08] Only word 0 is kept
        txw0_r <= reg_wdata;
      end
    end
  end

  // Channel enable arbitration against the two-wire port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // [RULE_16] Disabled out of reset
      enable_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (reg_wr && reg_hit(reg_addr, `REG_MODULE_CTRL)) begin
      if (reg_wdata[`MCR_ENABLE_BIT] && dap_attached && !enable_r) begin
        // [RULE_15] Port keeps priority
        enable_r <= 1'b0;
        refused_r <= 1'b1;
      end else begin
        // [RULE_13] Enable bit
        enable_r <= reg_wdata[`MCR_ENABLE_BIT];
        refused_r <= 1'b0;
      end
    end
  end

  // [RULE_14] Lock out later attach
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dap_attach_block <= 1'b0;
    end else begin
      dap_attach_block <= enable_r;
    end
  end

  // Register reads: data stand one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_MODULE_CTRL: begin
          reg_rdata <= {mcr_r[31:`MCR_ENABLE_BIT + 1], enable_r,
                        mcr_r[`MCR_NODE_HI:0]};
        end
        `REG_STD_FILTER: begin
          reg_rdata <= std_filter_r;
        end
        `REG_EXT_FILTER: begin
          reg_rdata <= ext_filter_r;
        end
        `REG_RXBUF_CFG: begin
          reg_rdata <= rxbuf_cfg_r;
        end
        `REG_TXBUF_CFG: begin
          reg_rdata <= txbuf_cfg_r;
        end
        `REG_BUF_ADDR: begin
          reg_rdata <= buf_addr_r;
        end
        `REG_TXBUF_WORD0: begin
          reg_rdata <= txw0_r;
        end
        `REG_STATUS: begin
          reg_rdata <= {8'h00, reply_cnt_r, drop_cnt_r, 4'h0, refused_r,
                        addr_ok, (state_r != ST_IDLE), enable_r};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // [RULE_04] Store request in buffer 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxbuf_r[0] <= 32'h0000_0000;
      rxbuf_r[1] <= 32'h0000_0000;
      req_write_r <= 1'b0;
      req_fdf_r <= 1'b0;
      req_brs_r <= 1'b0;
    end else if (accept) begin
      rxbuf_r[0] <= rx_data[31:0];
      rxbuf_r[1] <= rx_data[63:32];
      req_write_r <= (rx_dlc == `DLC_WRITE_REQ);
      req_fdf_r <= rx_fdf;
      req_brs_r <= rx_fdf && rx_brs;
    end
  end

  // [RULE_19] Normal receive path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      norm_valid <= 1'b0;
      norm_id <= 29'h0000000;
      norm_ext <= 1'b0;
      norm_dlc <= 4'h0;
      norm_data <= 64'h0000_0000_0000_0000;
    end else begin
      norm_valid <= rx_valid && !debug_frame;
      if (rx_valid && !debug_frame) begin
        norm_id <= rx_id;
        norm_ext <= rx_ext;
        norm_dlc <= rx_dlc;
        norm_data <= rx_data;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (dbg_ack) begin
          state_nxt = ST_REPLY;
        end
      end
      ST_REPLY: begin
        // [RULE_01] One reply, then idle
        if (tx_ready) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Debug access bus towards the on-chip debug system
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbg_req <= 1'b0;
      dbg_addr <= 32'h0000_0000;
      dbg_wdata <= 32'h0000_0000;
      dbg_we <= 1'b0;
    end else begin
      dbg_req <= (state_nxt == ST_ACCESS);
      if (accept) begin
        dbg_addr <= rx_data[31:0];
        dbg_wdata <= rx_data[63:32];
        dbg_we <= (rx_dlc == `DLC_WRITE_REQ);
      end
    end
  end

  // Reply frame built in transmit buffer 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_id <= 29'h0000000;
      tx_ext <= 1'b0;
      tx_fdf <= 1'b0;
      tx_brs <= 1'b0;
      tx_dlc <= 4'h0;
      tx_data <= 32'h0000_0000;
    end else if (state_r == ST_ACCESS && dbg_ack) begin
      tx_valid <= 1'b1;
      // [RULE_08] Identifier format
      tx_ext <= txw0_r[`TXW0_EXT_BIT];
      // [RULE_09] Reply identifier
      tx_id <= reply_id(txw0_r);
      // [RULE_02] Copy request format
      tx_fdf <= req_fdf_r;
      tx_brs <= req_brs_r;
      // [RULE_10] Generated length and data
      tx_dlc <= req_write_r ? `DLC_WRITE_REPLY : `DLC_READ_REPLY;
      tx_data <= req_write_r ? 32'h0000_0000 : dbg_rdata;
    end else if (state_r == ST_REPLY && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Counters saturate so software sees a stuck channel, not a wrap.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drop_cnt_r <= 8'h00;
    end else if (rx_valid && debug_frame && state_r != ST_IDLE &&
                 drop_cnt_r != 8'hff) begin
      drop_cnt_r <= drop_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reply_cnt_r <= 8'h00;
    end else if (state_r == ST_REPLY && tx_ready &&
                 reply_cnt_r != 8'hff) begin
      reply_cnt_r <= reply_cnt_r + 8'h01;
    end
  end

endmodule : can_message_debug_channel

/* testbench/debug_target_model.sv */
`timescale 1ns/1ns
module debug_target_model
  import can_debug_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lag,
  input wire logic dbg_req,
  input wire can_debug_pkg::word_t dbg_addr,
  input wire logic tx_valid,
  output logic dbg_ack,
  output can_debug_pkg::word_t dbg_rdata,
  output logic tx_ready
);
  logic [3:0] ack_cnt_r;
  logic [3:0] rdy_cnt_r;

  // Read data toggles outside the ack so a late sample shows garbage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_cnt_r <= 4'h0;
      dbg_ack <= 1'b0;
      dbg_rdata <= '0;
    end else begin
      dbg_ack <= dbg_req && !dbg_ack && ack_cnt_r == lag;
      ack_cnt_r <= (dbg_req && !dbg_ack) ? ack_cnt_r + 4'h1 : 4'h0;
      dbg_rdata <= ~dbg_rdata;
      if (dbg_req && !dbg_ack && ack_cnt_r == lag)
        dbg_rdata <= dbg_addr ^ 32'h5a5a_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_cnt_r <= 4'h0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= tx_valid && !tx_ready && rdy_cnt_r == lag;
      rdy_cnt_r <= (tx_valid && !tx_ready) ? rdy_cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : debug_target_model

/* testbench/dbg_chan_assertions.sv */
`timescale 1ns/1ns
module dbg_chan_chk
  import can_debug_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire can_debug_pkg::reg_addr_t reg_addr,
  input wire can_debug_pkg::word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic rx_valid,
  input wire logic norm_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_fdf,
  input wire logic tx_brs,
  input wire logic [3:0] tx_dlc,
  input wire can_debug_pkg::word_t tx_data,
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic dbg_ack,
  input wire can_debug_pkg::word_t dbg_rdata,
  input wire logic dap_attached,
  input wire logic dap_attach_block
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_done;
    dbg_req && dbg_ack;
  endsequence
  sequence s_mcr(logic on);
    reg_wr && reg_addr == 8'h00 && reg_wdata[27] == on;
  endsequence

  property p_reply;
    s_done |=> tx_valid && !dbg_req;
  endproperty
  a_reply: assert property (p_reply)
    else $error("ack gave no reply");
  property p_take;
    tx_valid && tx_ready |=> !tx_valid;
  endproperty
  a_take: assert property (p_take)
    else $error("reply held after take");
  property p_brs;
    tx_valid |-> tx_fdf || !tx_brs;
  endproperty
  a_brs: assert property (p_brs)
    else $error("rate switch without fd");
  property p_wr_rep;
    s_done ##0 dbg_we |=> tx_dlc == 4'h0 && tx_data == 32'h0;
  endproperty
  a_wr_rep: assert property (p_wr_rep)
    else $error("bad write reply");
  property p_rd_rep;
    s_done ##0 !dbg_we |=> tx_dlc == 4'h4 && tx_data == $past(dbg_rdata);
  endproperty
  a_rd_rep: assert property (p_rd_rep)
    else $error("bad read reply");
  property p_on;
    s_mcr(1'b1) ##0 !dap_attached |=> ##1 dap_attach_block;
  endproperty
  a_on: assert property (p_on)
    else $error("attach not blocked");
  property p_off;
    s_mcr(1'b0) |=> ##1 !dap_attach_block;
  endproperty
  a_off: assert property (p_off)
    else $error("block kept when off");
  property p_refuse;
    s_mcr(1'b1) ##0 dap_attached && !dap_attach_block && !$past(reg_wr)
      |=> ##1 !dap_attach_block;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("enabled over attached port");
  property p_norm;
    rx_valid && !dap_attach_block && !$past(reg_wr) |=> norm_valid;
  endproperty
  a_norm: assert property (p_norm)
    else $error("frame lost while off");
endmodule : dbg_chan_chk

bind can_message_debug_channel dbg_chan_chk u_chk (
  .clk(clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .rx_valid(rx_valid),
  .norm_valid(norm_valid),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .tx_fdf(tx_fdf),
  .tx_brs(tx_brs),
  .tx_dlc(tx_dlc),
  .tx_data(tx_data),
  .dbg_req(dbg_req),
  .dbg_we(dbg_we),
  .dbg_ack(dbg_ack),
  .dbg_rdata(dbg_rdata),
  .dap_attached(dap_attached),
  .dap_attach_block(dap_attach_block)
);

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
  import can_debug_pkg::*;
  localparam logic [10:0] REQ_ID = 11'h123;
  localparam logic [10:0] REP_ID = 11'h012;
  localparam can_id_t EXT_REQ = 29'h0abc_def1;
  localparam can_id_t EXT_REP = 29'h0000_0042;
  localparam node_t NODE = 3'h5;
  logic clk, rst, reg_wr, reg_rd, rx_valid, rx_ext, rx_fdf, rx_brs;
  logic rx_first_module, tx_ready, dbg_ack, dap_attached, norm_valid;
  logic norm_ext, tx_valid, tx_ext, tx_fdf, tx_brs, dbg_req, dbg_we;
  logic dap_attach_block;
  logic [3:0] rx_dlc, norm_dlc, tx_dlc, lag;
  logic [63:0] rx_data, norm_data;
  reg_addr_t reg_addr;
  word_t reg_wdata, reg_rdata, tx_data, dbg_addr, dbg_wdata, dbg_rdata;
  word_t rd_v;
  can_id_t rx_id, norm_id, tx_id;
  node_t rx_node;
  int mismatches, check_count;

  can_message_debug_channel u_dut (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_valid(rx_valid),
    .rx_id(rx_id),
    .rx_ext(rx_ext),
    .rx_fdf(rx_fdf),
    .rx_brs(rx_brs),
    .rx_dlc(rx_dlc),
    .rx_data(rx_data),
    .rx_node(rx_node),
    .rx_first_module(rx_first_module),
    .norm_valid(norm_valid),
    .norm_id(norm_id),
    .norm_ext(norm_ext),
    .norm_dlc(norm_dlc),
    .norm_data(norm_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_id(tx_id),
    .tx_ext(tx_ext),
    .tx_fdf(tx_fdf),
    .tx_brs(tx_brs),
    .tx_dlc(tx_dlc),
    .tx_data(tx_data),
    .dbg_req(dbg_req),
    .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata),
    .dbg_we(dbg_we),
    .dbg_ack(dbg_ack),
    .dbg_rdata(dbg_rdata),
    .dap_attached(dap_attached),
    .dap_attach_block(dap_attach_block)
  );
  debug_target_model u_far (
    .clk(clk),
    .rst(rst),
    .lag(lag),
    .dbg_req(dbg_req),
    .dbg_addr(dbg_addr),
    .tx_valid(tx_valid),
    .dbg_ack(dbg_ack),
    .dbg_rdata(dbg_rdata),
    .tx_ready(tx_ready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Tasks start and end on a rising edge; outputs read there are the
  // values launched one edge earlier.
  // Idle edge after a write so the strobe is never set twice at once
  task automatic wr(input reg_addr_t a, input word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input reg_addr_t a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_v = reg_rdata;
  endtask : rd

  task automatic wait_tx(input logic lvl);
    for (int n = 0; tx_valid !== lvl; n++) begin
      if (n == 60) begin
        chk(tx_valid, lvl);
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_tx

  task automatic send(input can_id_t id, input logic ext, we, fdf, brs,
                      input node_t nd, input logic fm);
    @(posedge clk);
    rx_id <= id;
    rx_ext <= ext;
    rx_fdf <= fdf;
    rx_brs <= brs;
    rx_dlc <= we ? 4'h8 : 4'h4;
    rx_data <= {~{3'h0, id}, 3'h0, id};
    rx_node <= nd;
    rx_first_module <= fm;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    @(posedge clk);
  endtask : send

  task automatic answer(input logic we, fdf, brs, ext, input can_id_t rid,
                        input word_t a);
    chk(dbg_req, 1'b1);
    chk(dbg_addr, a);
    chk(dbg_we, we);
    if (we)
      chk(dbg_wdata, word_t'(~a));
    wait_tx(1'b1);
    chk(tx_id, rid);
    chk(tx_ext, ext);
    chk(tx_fdf, fdf);
    chk(tx_brs, fdf & brs);
    chk(tx_dlc, we ? 4'h0 : 4'h4);
    chk(tx_data, we ? 32'h0 : a ^ 32'h5a5a_0000);
    wait_tx(1'b0);
  endtask : answer

  task automatic setup(input logic [15:0] rxa);
    wr(8'h04, {2'h0, 3'h7, REQ_ID, 5'h0, 11'h0});
    wr(8'h0c, 32'h0000_0400);
    wr(8'h10, 32'h0000_0800);
    // Word addresses: the config words keep the two byte bits
    wr(8'h14, {16'h0200, rxa});
    wr(8'h18, {3'h0, REP_ID, 18'h0});
    wr(8'h00, {4'h0, 1'b1, NODE, 24'h0});
  endtask : setup

  task automatic t_std;
    setup(16'h0100);
    for (int i = 0; i < 8; i++) begin
      lag <= 4'(i);
      send(REQ_ID, 1'b0, i[2], i[1], i[0], NODE, 1'b1);
      answer(i[2], i[1], i[0], 1'b0, REP_ID, {21'h0, REQ_ID});
    end
    lag <= 4'h8;
    send(REQ_ID, 1'b0, 1'b0, 1'b0, 1'b0, NODE, 1'b1);
    send(REQ_ID, 1'b0, 1'b0, 1'b0, 1'b0, NODE, 1'b1);
    chk(norm_valid, 1'b0);
    wait_tx(1'b1);
    wait_tx(1'b0);
    rd(8'h1c);
    chk(rd_v[15:8], 8'h01);
    chk(rd_v[23:16], 8'h09);
    $display("standard requests done");
  endtask : t_std

  task automatic t_filter;
    can_id_t id;
    for (int i = 0; i < 6; i++) begin
      if (i == 4)
        wr(8'h04, {2'h0, 3'h6, REQ_ID, 16'h0});
      if (i == 5)
        wr(8'h04, {2'h0, 3'h7, REQ_ID, 5'h0, 11'h001});
      id = (i == 0) ? can_id_t'(REQ_ID ^ 11'h1) : can_id_t'(REQ_ID);
      send(id, i == 1, 1'b0, 1'b0, 1'b0,
           i == 2 ? NODE + 3'h1 : NODE, i != 3);
      chk(norm_valid, 1'b1);
      chk(norm_id, id);
      chk(norm_ext, i == 1);
      chk(norm_dlc, 4'h4);
      chk(norm_data, {~{3'h0, id}, 3'h0, id});
      chk(dbg_req, 1'b0);
    end
    $display("filter done");
  endtask : t_filter

  task automatic t_ext;
    wr(8'h08, {3'h4, EXT_REQ});
    wr(8'h18, {3'h2, EXT_REP});
    send(EXT_REQ, 1'b1, 1'b1, 1'b1, 1'b0, NODE, 1'b1);
    answer(1'b1, 1'b1, 1'b0, 1'b1, EXT_REP, {3'h0, EXT_REQ});
    setup(16'h0400);
    rd(8'h1c);
    chk(rd_v[2], 1'b0);
    send(REQ_ID, 1'b0, 1'b0, 1'b0, 1'b0, NODE, 1'b1);
    chk(norm_valid, 1'b1);
    $display("extended and address done");
  endtask : t_ext

  task automatic t_enable;
    setup(16'h0100);
    rd(8'h00);
    chk(rd_v[27], 1'b1);
    chk(dap_attach_block, 1'b1);
    wr(8'h00, 32'h0);
    rd(8'h1c);
    chk(rd_v[0], 1'b0);
    chk(dap_attach_block, 1'b0);
    dap_attached <= 1'b1;
    wr(8'h00, {4'h0, 1'b1, NODE, 24'h0});
    rd(8'h1c);
    chk(rd_v[3:0], 4'hc);
    chk(dap_attach_block, 1'b0);
    send(REQ_ID, 1'b0, 1'b0, 1'b0, 1'b0, NODE, 1'b1);
    chk(norm_valid, 1'b1);
    dap_attached <= 1'b0;
    wr(8'h00, {4'h0, 1'b1, NODE, 24'h0});
    wr(8'h1c, 32'h0);
    rd(8'h1c);
    chk(rd_v[0], 1'b1);
    rd(8'h40);
    chk(rd_v, 32'h0);
    $display("enable done");
  endtask : t_enable

  initial begin
    {reg_wr, reg_rd, rx_valid, rx_ext, rx_fdf, rx_brs} = '0;
    {rx_first_module, dap_attached, lag, rx_dlc, rx_node} = '0;
    {reg_addr, reg_wdata, rx_id, rx_data} = '0;
    mismatches = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00);
    chk(rd_v, 32'h0);
    t_std();
    t_filter();
    t_ext();
    t_enable();
    wrap_up();
  end
endmodule : tb
